// ==== bench/tcp_timer_tb.sv ====
`define CHK(nm, ex, got) begin \
   compares++; \
   if ((got) !== (ex)) begin \
      bad_count++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
   end \
end

module tcp_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  clk;
   logic                  rst_b;
   tcp_pkg::tcp_avm_req_t req;
   tcp_pkg::tcp_avm_rsp_t rsp;
   logic                  ext_pin;
   logic                  gie;
   logic                  cmp_ack;
   logic                  ovf_ack;
   logic                  cmp_irq;
   logic                  ovf_irq;
   logic                  pin;
   logic                  conn;
   int                    bad_count;
   int                    compares;
   int                    cycles;
   logic [7:0]            rd;

   tcp_timer uut (
      .clk                 (clk),
      .rst_b               (rst_b),
      .avm_req             (req),
      .avm_rsp             (rsp),
      .ext_count_pin       (ext_pin),
      .global_irq_enable   (gie),
      .compare_vector_ack  (cmp_ack),
      .overflow_vector_ack (ovf_ack),
      .compare_irq         (cmp_irq),
      .overflow_irq        (ovf_irq),
      .compare_out_pin     (pin),
      .compare_out_connect (conn)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic stop_test();
      if (bad_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         stop_test();
      end
   end

   // One Avalon transfer; called and returns just after a rising edge
   task automatic bus(input logic wr, input logic [6:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
      req.read       <= ~wr;
      req.write      <= wr;
      req.address    <= {idx, 2'h0};
      req.writedata  <= {24'h000000, d};
      req.byteenable <= 4'hF;
      do begin
         @(posedge clk);
      end while (rsp.waitrequest !== 1'b0);
      q = rsp.readdata[7:0];
      req.read  <= 1'b0;
      req.write <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask : wr

   task automatic rd_chk(input string nm, input logic [6:0] idx,
                         input logic [7:0] ex);
      bus(1'b0, idx, 8'h00, rd);
      `CHK(nm, ex, rd)
   endtask : rd_chk

   task automatic t_reset();
      rd_chk("ctrl_rst", tcp_pkg::IDX_CTRL, 8'h00);
      rd_chk("mask_rst", tcp_pkg::IDX_MASK, 8'h00);
      rd_chk("flags_rst", tcp_pkg::IDX_FLAGS, 8'h00);
      rd_chk("unmapped", 7'h10, 8'h00);
      `CHK("conn_rst", 1'b0, conn)
      wr(tcp_pkg::IDX_MASK, 8'hFF);
      rd_chk("mask_unused", tcp_pkg::IDX_MASK, 8'h03);
      wr(tcp_pkg::IDX_MASK, 8'h00);
   endtask : t_reset

   task automatic t_force();
      logic [7:0] ctl [4] = '{8'hB0, 8'hA0, 8'h90, 8'h90};
      logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 4; i++) begin
         wr(tcp_pkg::IDX_CTRL, ctl[i]);
         `CHK("force_pin", exp[i], pin)
         `CHK("force_conn", 1'b1, conn)
      end
      rd_chk("force_reads0", tcp_pkg::IDX_CTRL, 8'h10);
      wr(tcp_pkg::IDX_COUNT, 8'h33);
      wr(tcp_pkg::IDX_COMPARE, 8'h33);
      wr(tcp_pkg::IDX_CTRL, 8'hB8);
      `CHK("force_ctc_pin", 1'b1, pin)
      rd_chk("force_no_clr", tcp_pkg::IDX_COUNT, 8'h33);
      rd_chk("force_no_flag", tcp_pkg::IDX_FLAGS, 8'h00);
      wr(tcp_pkg::IDX_CTRL, 8'hA0);
      wr(tcp_pkg::IDX_CTRL, 8'h00);
      `CHK("disc_conn", 1'b0, conn)
   endtask : t_force

   task automatic wait_irq(input logic which);
      int n;
      n = 0;
      while ((which ? ovf_irq : cmp_irq) !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_irq

   task automatic t_flags();
      wr(tcp_pkg::IDX_COMPARE, 8'h05);
      wr(tcp_pkg::IDX_COUNT, 8'h03);
      wr(tcp_pkg::IDX_FLAGS, 8'hFF);
      wr(tcp_pkg::IDX_MASK, 8'h03);
      gie <= 1'b1;
      wr(tcp_pkg::IDX_CTRL, 8'h11);
      wait_irq(1'b0);
      `CHK("cmp_irq", 1'b1, cmp_irq)
      `CHK("toggle_pin", 1'b1, pin)
      wr(tcp_pkg::IDX_FLAGS, 8'hFD);
      rd_chk("w1c_other", tcp_pkg::IDX_FLAGS, 8'h02);
      wr(tcp_pkg::IDX_FLAGS, 8'h02);
      rd_chk("cmp_w1c", tcp_pkg::IDX_FLAGS, 8'h00);
      wait_irq(1'b1);
      `CHK("ovf_irq", 1'b1, ovf_irq)
      ovf_ack <= 1'b1;
      @(posedge clk);
      ovf_ack <= 1'b0;
      @(posedge clk);
      `CHK("ovf_vec_clr", 1'b0, ovf_irq)
      wait_irq(1'b0);
      gie <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      `CHK("gie_masks", 1'b0, cmp_irq)
      cmp_ack <= 1'b1;
      gie     <= 1'b1;
      @(posedge clk);
      cmp_ack <= 1'b0;
      @(posedge clk);
      `CHK("cmp_vec_clr", 1'b0, cmp_irq)
      wr(tcp_pkg::IDX_CTRL, 8'h00);
      wr(tcp_pkg::IDX_MASK, 8'h00);
   endtask : t_flags

   task automatic t_ctc();
      wr(tcp_pkg::IDX_COMPARE, 8'h03);
      wr(tcp_pkg::IDX_COUNT, 8'h00);
      wr(tcp_pkg::IDX_FLAGS, 8'h03);
      wr(tcp_pkg::IDX_CTRL, 8'h29);
      repeat (300) @(posedge clk);
      wr(tcp_pkg::IDX_CTRL, 8'h28);
      bus(1'b0, tcp_pkg::IDX_COUNT, 8'h00, rd);
      `CHK("ctc_top", 1'b1, rd <= 8'h03)
      rd_chk("ctc_flags", tcp_pkg::IDX_FLAGS, 8'h02);
   endtask : t_ctc

   task automatic t_cnt_write();
      wr(tcp_pkg::IDX_CTRL, 8'h00);
      wr(tcp_pkg::IDX_COMPARE, 8'h20);
      wr(tcp_pkg::IDX_COUNT, 8'h20);
      rd_chk("cnt_rw", tcp_pkg::IDX_COUNT, 8'h20);
      wr(tcp_pkg::IDX_FLAGS, 8'h03);
      wr(tcp_pkg::IDX_CTRL, 8'h01);
      repeat (20) @(posedge clk);
      wr(tcp_pkg::IDX_CTRL, 8'h00);
      rd_chk("blocked", tcp_pkg::IDX_FLAGS, 8'h00);
   endtask : t_cnt_write

   task automatic t_prescale();
      int div [5] = '{1, 8, 64, 256, 1024};
      for (int i = 0; i < 5; i++) begin
         wr(tcp_pkg::IDX_COUNT, 8'h00);
         wr(tcp_pkg::IDX_CTRL, 8'(i + 1));
         repeat (4 * div[i] - 3) @(posedge clk);
         wr(tcp_pkg::IDX_CTRL, 8'h00);
         rd_chk("prescale", tcp_pkg::IDX_COUNT, 8'h04);
      end
   endtask : t_prescale

   task automatic t_ext();
      for (int e = 0; e < 2; e++) begin
         wr(tcp_pkg::IDX_COUNT, 8'h00);
         wr(tcp_pkg::IDX_CTRL, e ? 8'h07 : 8'h06);
         repeat (3) begin
            ext_pin <= 1'b1;
            repeat (6) @(posedge clk);
            ext_pin <= 1'b0;
            repeat (6) @(posedge clk);
         end
         wr(tcp_pkg::IDX_CTRL, 8'h00);
         rd_chk("ext_edges", tcp_pkg::IDX_COUNT, 8'h03);
      end
   endtask : t_ext

   task automatic t_pwm();
      logic [7:0] ctl [6] = '{8'h69, 8'h79, 8'h69, 8'h61, 8'h61, 8'h71};
      logic [7:0] cmp [6] = '{8'h80, 8'h80, 8'hFF, 8'h80, 8'hFF, 8'h80};
      int         win [6] = '{256, 256, 256, 510, 510, 510};
      int         hi  [6] = '{129, 127, 256, 256, 510, 254};
      int         n;
      for (int i = 0; i < 6; i++) begin
         wr(tcp_pkg::IDX_CTRL, 8'h00);
         wr(tcp_pkg::IDX_COMPARE, cmp[i]);
         wr(tcp_pkg::IDX_CTRL, ctl[i]);
         repeat (1100) @(posedge clk);
         n = 0;
         repeat (win[i]) begin
            @(posedge clk);
            n += (pin === 1'b1) ? 1 : 0;
         end
         `CHK("pwm_duty", hi[i], n)
         `CHK("pwm_conn", 1'b1, conn)
      end
      wr(tcp_pkg::IDX_CTRL, 8'h00);
   endtask : t_pwm

   initial begin
      bad_count = 0;
      compares  = 0;
      cycles    = 0;
      rst_b     = 1'b0;
      req       = '0;
      ext_pin   = 1'b0;
      gie       = 1'b0;
      cmp_ack   = 1'b0;
      ovf_ack   = 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_force();
      t_flags();
      t_ctc();
      t_cnt_write();
      t_prescale();
      t_ext();
      t_pwm();
      stop_test();
   end
endmodule : tcp_timer_tb

// ==== hw/tcp_pkg.sv ====
package tcp_pkg;

   // Register word indices; the byte address is four times the index
   localparam logic [6:0] IDX_CTRL    = 7'h44;
   localparam logic [6:0] IDX_MASK    = 7'h6E;
   localparam logic [6:0] IDX_FLAGS   = 7'h45;
   localparam logic [6:0] IDX_COUNT   = 7'h46;
   localparam logic [6:0] IDX_COMPARE = 7'h47;
   localparam int         ADDR_W      = 9;

   // Control register fields
   localparam int CTRL_FORCE_BIT = 7;
   localparam int CTRL_WAVE_LO   = 6;
   localparam int CTRL_COM_HI    = 5;
   localparam int CTRL_WAVE_HI   = 3;
   localparam int CTRL_CS_HI     = 2;

   // Mask and flag register fields
   localparam int MASK_CMP_BIT = 1;
   localparam int MASK_OVF_BIT = 0;
   localparam int FLAG_CMP_BIT = 1;
   localparam int FLAG_OVF_BIT = 0;

   // Reset values
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [1:0] MASK_RST  = 2'h0;
   localparam logic [1:0] FLAGS_RST = 2'h0;

   // Counter extremes
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;

   // Prescaler taps
   localparam int         PRE_W       = 10;
   localparam logic [9:0] PRE_DIV8    = 10'h007;
   localparam logic [9:0] PRE_DIV64   = 10'h03F;
   localparam logic [9:0] PRE_DIV256  = 10'h0FF;
   localparam logic [9:0] PRE_DIV1024 = 10'h3FF;

   // Compare output actions
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   typedef enum logic [1:0] {
      WAVE_NORMAL = 2'h0,
      WAVE_PC_PWM = 2'h1,
      WAVE_CTC    = 2'h2,
      WAVE_FAST   = 2'h3
   } tcp_wave_t;

   typedef enum logic [2:0] {
      CS_STOP    = 3'h0,
      CS_DIV1    = 3'h1,
      CS_DIV8    = 3'h2,
      CS_DIV64   = 3'h3,
      CS_DIV256  = 3'h4,
      CS_DIV1024 = 3'h5,
      CS_EXT_FALL = 3'h6,
      CS_EXT_RISE = 3'h7
   } tcp_clk_t;

   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [31:0]       writedata;
      logic [3:0]        byteenable;
   } tcp_avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } tcp_avm_rsp_t;

   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic [7:0]       cnt;
      logic [7:0]       ocr_buf;
      logic [7:0]       ocr_act;
      logic             dir_down;
      logic             block;
      logic             oc;
      tcp_wave_t        mode;
      logic [1:0]       com;
      tcp_clk_t         cs;
      logic [1:0]       mask;
      logic [1:0]       flags;
      logic             ack;
      logic [7:0]       rdata;
      logic             ext_s1;
      logic             ext_s2;
      logic             ext_prev;
   } tcp_state_t;

   localparam tcp_state_t STATE_RST = '0;

endpackage : tcp_pkg

// ==== hw/tcp_timer.sv ====
module tcp_timer (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // Register bus
   input  wire tcp_pkg::tcp_avm_req_t avm_req,
   output tcp_pkg::tcp_avm_rsp_t      avm_rsp,
   // External count pin
   input  wire logic                  ext_count_pin,
   // CPU interrupt side
   input  wire logic                  global_irq_enable,
   input  wire logic                  compare_vector_ack,
   input  wire logic                  overflow_vector_ack,
   output logic                       compare_irq,
   output logic                       overflow_irq,
   // Compare output pin
   output logic                       compare_out_pin,
   output logic                       compare_out_connect
);

   tcp_pkg::tcp_state_t s_r;
   tcp_pkg::tcp_state_t s_nxt;

   logic [6:0] idx;
   logic       wr;
   logic [7:0] wd;
   logic       tick;
   logic       pwm;
   logic [7:0] ocr_eff;
   logic       match;
   logic       ovf_ev;
   logic       ignore_top;
   logic       force_ev;
   logic [1:0] clr;
   logic       ctrl_wr;
   tcp_pkg::tcp_wave_t wmode;

   assign idx = avm_req.address[tcp_pkg::ADDR_W-1:2];
   assign wd  = avm_req.writedata[7:0];
   assign wr  = avm_req.write & s_r.ack & avm_req.byteenable[0];
   assign ctrl_wr = wr & (idx == tcp_pkg::IDX_CTRL);
   assign wmode = tcp_pkg::tcp_wave_t'({wd[tcp_pkg::CTRL_WAVE_HI],
                                        wd[tcp_pkg::CTRL_WAVE_LO]});

   // Timer clock selection
   always_comb begin
      unique case (s_r.cs)
         tcp_pkg::CS_STOP:     tick = 1'b0;
         tcp_pkg::CS_DIV1:     tick = 1'b1;
         tcp_pkg::CS_DIV8:
            tick = (s_r.pre & tcp_pkg::PRE_DIV8) == tcp_pkg::PRE_DIV8;
         tcp_pkg::CS_DIV64:
            tick = (s_r.pre & tcp_pkg::PRE_DIV64) == tcp_pkg::PRE_DIV64;
         tcp_pkg::CS_DIV256:
            tick = (s_r.pre & tcp_pkg::PRE_DIV256) == tcp_pkg::PRE_DIV256;
         tcp_pkg::CS_DIV1024:
            tick = s_r.pre == tcp_pkg::PRE_DIV1024;
         // Pin is read regardless of its direction
         tcp_pkg::CS_EXT_FALL: tick = s_r.ext_prev & ~s_r.ext_s2;
         tcp_pkg::CS_EXT_RISE: tick = ~s_r.ext_prev & s_r.ext_s2;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      pwm = (s_r.mode == tcp_pkg::WAVE_PC_PWM) ||
            (s_r.mode == tcp_pkg::WAVE_FAST);
      // Non-PWM modes see compare writes at once
      ocr_eff = pwm ? s_r.ocr_act : s_r.ocr_buf;
      match = tick & (s_r.cnt == ocr_eff) & ~s_r.block;
      ignore_top = s_r.com[1] & (ocr_eff == tcp_pkg::CNT_MAX);
      force_ev = ctrl_wr & wd[tcp_pkg::CTRL_FORCE_BIT] &
                 ~wmode[0];
      ovf_ev = 1'b0;

      // Bus handshake: one wait cycle, then completion
      s_nxt.ack = (avm_req.read | avm_req.write) & ~s_r.ack;

      // Pin synchroniser and prescaler
      s_nxt.ext_s1   = ext_count_pin;
      s_nxt.ext_s2   = s_r.ext_s1;
      s_nxt.ext_prev = s_r.ext_s2;
      s_nxt.pre      = s_r.pre + 10'h001;

      if (!pwm) begin
         s_nxt.ocr_act = s_r.ocr_buf;
      end

      // Counting sequence
      if (tick) begin
         s_nxt.block = 1'b0;
         unique case (s_r.mode)
            tcp_pkg::WAVE_NORMAL, tcp_pkg::WAVE_FAST: begin
               s_nxt.cnt = s_r.cnt + 8'h01;
               ovf_ev = s_r.cnt == tcp_pkg::CNT_MAX;
               if (s_r.mode == tcp_pkg::WAVE_FAST &&
                   s_r.cnt == tcp_pkg::CNT_MAX) begin
                  s_nxt.ocr_act = s_r.ocr_buf;
               end
            end
            tcp_pkg::WAVE_CTC: begin
               // Compare value is TOP here
               s_nxt.cnt = match ? tcp_pkg::CNT_BOTTOM
                                 : s_r.cnt + 8'h01;
               ovf_ev = s_r.cnt == tcp_pkg::CNT_MAX;
            end
            tcp_pkg::WAVE_PC_PWM: begin
               if (!s_r.dir_down) begin
                  if (s_r.cnt == tcp_pkg::CNT_MAX) begin
                     s_nxt.dir_down = 1'b1;
                     s_nxt.cnt = s_r.cnt - 8'h01;
                     s_nxt.ocr_act = s_r.ocr_buf;
                  end else begin
                     s_nxt.cnt = s_r.cnt + 8'h01;
                  end
               end else if (s_r.cnt == tcp_pkg::CNT_BOTTOM) begin
                  s_nxt.dir_down = 1'b0;
                  s_nxt.cnt = s_r.cnt + 8'h01;
                  ovf_ev = 1'b1;
               end else begin
                  s_nxt.cnt = s_r.cnt - 8'h01;
               end
            end
         endcase
      end

      // Waveform generator
      unique case (s_r.mode)
         tcp_pkg::WAVE_NORMAL, tcp_pkg::WAVE_CTC: begin
            if (match) begin
               unique case (s_r.com)
                  tcp_pkg::COM_OFF:    s_nxt.oc = s_r.oc;
                  tcp_pkg::COM_TOGGLE: s_nxt.oc = ~s_r.oc;
                  tcp_pkg::COM_CLEAR:  s_nxt.oc = 1'b0;
                  tcp_pkg::COM_SET:    s_nxt.oc = 1'b1;
               endcase
            end
         end
         tcp_pkg::WAVE_FAST: begin
            if (s_r.com[1]) begin
               if (tick && s_r.cnt == tcp_pkg::CNT_MAX) begin
                  s_nxt.oc = ~s_r.com[0];
               end
               if (match && !ignore_top) begin
                  s_nxt.oc = s_r.com[0];
               end
            end
         end
         tcp_pkg::WAVE_PC_PWM: begin
            if (s_r.com[1]) begin
               if (match && !ignore_top) begin
                  s_nxt.oc = s_r.dir_down ? ~s_r.com[0]
                                          : s_r.com[0];
               end
               if (ignore_top && tick && !s_r.dir_down &&
                   s_r.cnt == tcp_pkg::CNT_MAX) begin
                  s_nxt.oc = ~s_r.com[0];
               end
            end
         end
      endcase

      // Forced compare touches only the pin, never flags or counter
      if (force_ev) begin
         unique case (wd[tcp_pkg::CTRL_COM_HI -: 2])
            tcp_pkg::COM_OFF:    s_nxt.oc = s_r.oc;
            tcp_pkg::COM_TOGGLE: s_nxt.oc = ~s_r.oc;
            tcp_pkg::COM_CLEAR:  s_nxt.oc = 1'b0;
            tcp_pkg::COM_SET:    s_nxt.oc = 1'b1;
         endcase
      end

      // Flags: hardware set wins over any clear
      clr = 2'h0;
      if (wr && idx == tcp_pkg::IDX_FLAGS) begin
         clr = wd[1:0];
      end
      clr[tcp_pkg::FLAG_CMP_BIT] = clr[tcp_pkg::FLAG_CMP_BIT] |
                                   compare_vector_ack;
      clr[tcp_pkg::FLAG_OVF_BIT] = clr[tcp_pkg::FLAG_OVF_BIT] |
                                   overflow_vector_ack;
      s_nxt.flags = (s_r.flags & ~clr) | {match, ovf_ev};

      // Register writes
      if (wr) begin
         unique case (idx)
            tcp_pkg::IDX_CTRL: begin
               s_nxt.mode = wmode;
               s_nxt.com  = wd[tcp_pkg::CTRL_COM_HI -: 2];
               s_nxt.cs   = tcp_pkg::tcp_clk_t'(wd[tcp_pkg::CTRL_CS_HI:0]);
            end
            tcp_pkg::IDX_MASK:    s_nxt.mask = wd[1:0];
            tcp_pkg::IDX_COUNT: begin
               s_nxt.cnt   = wd;
               s_nxt.block = 1'b1;
            end
            tcp_pkg::IDX_COMPARE: s_nxt.ocr_buf = wd;
            default: begin
            end
         endcase
      end

      // Read data captured during the wait cycle
      if (avm_req.read && !s_r.ack) begin
         unique case (idx)
            tcp_pkg::IDX_CTRL:
               s_nxt.rdata = {1'b0, s_r.mode[0], s_r.com,
                              s_r.mode[1], s_r.cs};
            tcp_pkg::IDX_MASK:    s_nxt.rdata = {6'h00, s_r.mask};
            tcp_pkg::IDX_FLAGS:   s_nxt.rdata = {6'h00, s_r.flags};
            tcp_pkg::IDX_COUNT:   s_nxt.rdata = s_r.cnt;
            tcp_pkg::IDX_COMPARE: s_nxt.rdata = s_r.ocr_buf;
            default:              s_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_r <= tcp_pkg::STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avm_rsp.readdata    = {24'h000000, s_r.rdata};
   assign avm_rsp.waitrequest = (avm_req.read | avm_req.write) & ~s_r.ack;
   assign compare_irq  = global_irq_enable &
                         s_r.mask[tcp_pkg::MASK_CMP_BIT] &
                         s_r.flags[tcp_pkg::FLAG_CMP_BIT];
   assign overflow_irq = global_irq_enable &
                         s_r.mask[tcp_pkg::MASK_OVF_BIT] &
                         s_r.flags[tcp_pkg::FLAG_OVF_BIT];
   assign compare_out_pin     = s_r.oc;
   assign compare_out_connect = |s_r.com;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_force_reads_zero: assert property (
      (avm_req.read && !s_r.ack && idx == tcp_pkg::IDX_CTRL)
      |=> !avm_rsp.readdata[tcp_pkg::CTRL_FORCE_BIT])
      else $error("force strobe read back as one");

   a_force_clears_pin: assert property (
      (ctrl_wr && !wmode[0] && wd[7] && wd[5:4] == tcp_pkg::COM_CLEAR)
      |=> !compare_out_pin)
      else $error("forced clear did not clear the pin");

   a_force_no_flag: assert property (
      (force_ev && !match && !s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      |=> !s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      else $error("forced compare set the compare flag");

   a_ctc_clear: assert property (
      (s_r.mode == tcp_pkg::WAVE_CTC && match && !wr)
      |=> s_r.cnt == tcp_pkg::CNT_BOTTOM)
      else $error("counter not cleared on match in clear mode");

   a_ovf_at_max: assert property (
      (tick && s_r.mode != tcp_pkg::WAVE_PC_PWM &&
       s_r.cnt == tcp_pkg::CNT_MAX && !(wr && idx == tcp_pkg::IDX_COUNT))
      |=> s_r.flags[tcp_pkg::FLAG_OVF_BIT] &&
          s_r.cnt == tcp_pkg::CNT_BOTTOM)
      else $error("overflow flag missing at MAX");

   a_pc_ovf_bottom: assert property (
      (tick && s_r.mode == tcp_pkg::WAVE_PC_PWM && s_r.dir_down &&
       s_r.cnt == tcp_pkg::CNT_BOTTOM && !wr)
      |=> s_r.flags[tcp_pkg::FLAG_OVF_BIT] && !s_r.dir_down &&
          s_r.cnt == 8'h01)
      else $error("phase mode bottom turn wrong");

   a_match_flag: assert property (
      (tick && s_r.cnt == ocr_eff && !s_r.block)
      |=> s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      else $error("compare flag not set on match");

   a_count_block: assert property (
      (wr && idx == tcp_pkg::IDX_COUNT && !s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      ##1 (tick && !s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      |=> !s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      else $error("match after counter write was not suppressed");

   a_stop_holds: assert property (
      (s_r.cs == tcp_pkg::CS_STOP && !wr) |=> $stable(s_r.cnt))
      else $error("counter moved with no clock source");

   a_irq_gate: assert property (
      compare_irq |-> global_irq_enable &&
      s_r.mask[tcp_pkg::MASK_CMP_BIT] && s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      else $error("compare interrupt without its conditions");

   a_mask_upper_zero: assert property (
      (avm_req.read && !s_r.ack && idx == tcp_pkg::IDX_MASK)
      |=> avm_rsp.readdata[7:2] == 6'h00)
      else $error("unused mask bits read nonzero");

   a_normal_step: assert property (
      (tick && s_r.mode == tcp_pkg::WAVE_NORMAL &&
       !(wr && idx == tcp_pkg::IDX_COUNT))
      |=> s_r.cnt == $past(s_r.cnt) + 8'h01)
      else $error("counter did not step on a timer tick");

   a_ext_rise: assert property (
      (s_r.cs == tcp_pkg::CS_EXT_RISE && !ctrl_wr &&
       s_r.ext_s1 && !s_r.ext_s2)
      |=> tick)
      else $error("rising pin edge gave no timer tick");

   a_ext_fall: assert property (
      (s_r.cs == tcp_pkg::CS_EXT_FALL && !ctrl_wr &&
       !s_r.ext_s1 && s_r.ext_s2)
      |=> tick)
      else $error("falling pin edge gave no timer tick");

   a_top_turn: assert property (
      (tick && s_r.mode == tcp_pkg::WAVE_PC_PWM && !s_r.dir_down &&
       s_r.cnt == tcp_pkg::CNT_MAX && !(wr && idx == tcp_pkg::IDX_COUNT))
      |=> s_r.dir_down && s_r.cnt == 8'hFE &&
          s_r.ocr_act == $past(s_r.ocr_buf))
      else $error("phase mode top turn wrong");

   a_fast_load: assert property (
      (tick && s_r.mode == tcp_pkg::WAVE_FAST &&
       s_r.cnt == tcp_pkg::CNT_MAX)
      |=> s_r.ocr_act == $past(s_r.ocr_buf))
      else $error("fast mode compare not loaded at bottom");

   a_cmp_sticky: assert property (
      (s_r.flags[tcp_pkg::FLAG_CMP_BIT] && !compare_vector_ack &&
       !(wr && idx == tcp_pkg::IDX_FLAGS && wd[tcp_pkg::FLAG_CMP_BIT]))
      |=> s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      else $error("compare flag dropped without a clear");

   a_ovf_sticky: assert property (
      (s_r.flags[tcp_pkg::FLAG_OVF_BIT] && !overflow_vector_ack &&
       !(wr && idx == tcp_pkg::IDX_FLAGS && wd[tcp_pkg::FLAG_OVF_BIT]))
      |=> s_r.flags[tcp_pkg::FLAG_OVF_BIT])
      else $error("overflow flag dropped without a clear");

   a_vec_clear: assert property (
      (compare_vector_ack && !match)
      |=> !s_r.flags[tcp_pkg::FLAG_CMP_BIT])
      else $error("vector acknowledge left the compare flag set");

   a_fast_bottom: assert property (
      (tick && s_r.mode == tcp_pkg::WAVE_FAST && s_r.com[1] &&
       s_r.cnt == tcp_pkg::CNT_MAX && !force_ev)
      |=> compare_out_pin != $past(s_r.com[0]))
      else $error("fast mode pin wrong at bottom");

   a_pc_match: assert property (
      (match && !ignore_top && s_r.mode == tcp_pkg::WAVE_PC_PWM &&
       s_r.com[1] && !force_ev)
      |=> compare_out_pin == ($past(s_r.com[0]) ^ $past(s_r.dir_down)))
      else $error("phase mode pin wrong on match");

   a_disc_hold: assert property (
      (s_r.mode == tcp_pkg::WAVE_NORMAL &&
       s_r.com == tcp_pkg::COM_OFF && !force_ev)
      |=> $stable(compare_out_pin))
      else $error("disconnected pin changed");

endmodule : tcp_timer
